// file: verilog/mbdc_top.v
// Diagnostic counters, reply builder and fallback line configuration
`timescale 1ns/1ns
`include "mbdc_regs.vh"
module mbdc_top #(
   parameter [31:0] SERIAL_NUM = 32'd12345, // Arbitrary value
   parameter [127:0] MODEL_ID = "MODEL-0000-AAAA " // Arbitrary value
) (
   input wire clk,
   input wire sys_rst,
   input wire req_valid,
   output wire req_ready,
   input wire [7:0] req_addr,
   input wire [7:0] req_func,
   input wire [15:0] req_word1,
   input wire [15:0] req_word2,
   input wire coil0_state,
   output wire tx_valid,
   input wire tx_ready,
   output wire [7:0] tx_data,
   output wire tx_last,
   input wire msg_done,
   input wire exc_sent,
   input wire [7:0] exc_code,
   input wire crc_err,
   input wire char_err,
   input wire port_restart,
   input wire [15:0] diag_set,
   input wire nv_load,
   input wire nv_ok,
   input wire [13:0] nv_cfg,
   input wire hw_fail,
   output wire nv_save,
   output wire [13:0] nv_wdata,
   output wire [7:0] cfg_addr,
   output wire [2:0] cfg_baud,
   output wire [1:0] cfg_parity,
   output wire cfg_stop,
   output wire irq,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready
);
   localparam ST_IDLE = 1'b0;
   localparam ST_SEND = 1'b1;
   localparam integer SN_LO = SERIAL_NUM % 100;
   // Factory address from the serial number tail
   localparam [7:0] FACT_ADDR = (SN_LO == 0) ? `MBDC_ADDR_SN00 : SN_LO[7:0];
   localparam [13:0] FACT_CFG = {`MBDC_STOP_ONE, `MBDC_PAR_EVEN, `MBDC_BAUD_19K2,
      FACT_ADDR};
   localparam [13:0] FALL_CFG = {`MBDC_STOP_ONE, `MBDC_PAR_EVEN, `MBDC_BAUD_19K2,
      `MBDC_ADDR_FALLBACK};

   // Field checks shared by bus writes and memory loads
   function addr_ok;
      input [7:0] a;
      addr_ok = (a >= `MBDC_ADDR_MIN) && (a <= `MBDC_ADDR_MAX);
   endfunction
   function cfg_ok;
      input [13:0] c;
      cfg_ok = addr_ok(c[`MBDC_CFG_ADDR]) && (c[`MBDC_CFG_BAUD] <= `MBDC_BAUD_MAX) &&
         (c[`MBDC_CFG_PAR] <= `MBDC_PAR_MAX);
   endfunction
   // Identity bank word: model text, then serial number
   function [15:0] ident_word;
      input [15:0] w;
      if (w < 16'h0008)
         ident_word = MODEL_ID[(127 - 16 * w) -: 16];
      else if (w == 16'h0008)
         ident_word = SERIAL_NUM[31:16];
      else
         ident_word = SERIAL_NUM[15:0];
   endfunction
   // Byte-lane merge for bus writes
   function [31:0] lane_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      reg [31:0] m;
      begin
         m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
         lane_merge = (old & ~m) | (nw & m);
      end
   endfunction

   reg st_q;
   reg [4:0] idx_q, len_q;
   reg [7:0] tx_q;
   reg [7:0] rsp_q [1:`MBDC_BUF_N-1];
   reg [15:0] cnt_q [0:3];
   reg [15:0] diag_q;
   reg [13:0] cfg_q;
   reg nv_save_q;
   reg [13:0] nv_wdata_q;
   reg [4:0] sts_q, en_q;
   reg aw_q, w_q, bvalid_q, rvalid_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q, rdata_q;
   reg [3:0] wstrb_q;
   reg [1:0] bresp_q, rresp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Request decode
   wire take = req_valid & req_ready;
   wire ours = (req_addr == cfg_q[`MBDC_CFG_ADDR]);
   wire go = take & ours;
   wire is_diag = (req_func == `MBDC_FC_DIAG);
   wire is_coil = (req_func == `MBDC_FC_COILS);
   wire [16:0] id_end = {1'b0, req_word1} + {1'b0, req_word2};
   reg excp;
   reg [7:0] ex_code;
   reg [15:0] dval;
   reg [4:0] len_d;
   // Supported requests and their reply lengths
   always @* begin
      excp = 1'b0;
      ex_code = `MBDC_EX_FUNC;
      dval = req_word2;
      len_d = `MBDC_LEN_DIAG;
      case (req_func)
         `MBDC_FC_DIAG: begin
            case (req_word1)
               `MBDC_SF_QUERY, `MBDC_SF_RESTART, `MBDC_SF_CLEAR: dval = req_word2;
               `MBDC_SF_DIAGREG: dval = diag_q;
               `MBDC_SF_BUSERR: dval = cnt_q[2];
               `MBDC_SF_EXCCNT: dval = cnt_q[0];
               `MBDC_SF_MSGCNT: dval = cnt_q[1];
               `MBDC_SF_CHRERR: dval = cnt_q[3];
               default: excp = 1'b1;
            endcase
         end
         `MBDC_FC_COILS: begin
            len_d = `MBDC_LEN_COIL;
            // Only coil 0 exists; it serves as a presence probe
            if (req_word1 != 16'h0000 || req_word2 != 16'h0001) begin
               excp = 1'b1;
               ex_code = `MBDC_EX_ADDR;
            end
         end
         `MBDC_FC_HOLD: begin
            len_d = `MBDC_LEN_EXC + {req_word2[3:0], 1'b0};
            if (req_word2 == 16'h0000 || req_word2 > `MBDC_ID_WORDS) begin
               excp = 1'b1;
               ex_code = `MBDC_EX_VALUE;
            end else if (id_end > {1'b0, `MBDC_ID_WORDS}) begin
               excp = 1'b1;
               ex_code = `MBDC_EX_ADDR;
            end
         end
         default: excp = 1'b1;
      endcase
      if (excp)
         len_d = `MBDC_LEN_EXC;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reply image, one byte per slot, high byte first
   wire [7:0] fc_out = excp ? (req_func | `MBDC_FC_EXC) : req_func;
   wire [7:0] byte2 = excp ? ex_code : is_diag ? req_word1[15:8] :
      is_coil ? 8'h01 : {req_word2[6:0], 1'b0};
   genvar gi;
   generate
      for (gi = 1; gi < `MBDC_BUF_N; gi = gi + 1) begin : g_fill
         wire [7:0] fb;
         if (gi == 1) begin : g_fc
            assign fb = fc_out;
         end else if (gi == 2) begin : g_b2
            assign fb = byte2;
         end else begin : g_dat
            localparam [15:0] K = (gi - 3) / 2;
            wire [15:0] iw = ident_word(req_word1 + K);
            wire [7:0] hb = ((gi - 3) % 2 == 0) ? iw[15:8] : iw[7:0];
            wire [7:0] db = (gi == 3) ? req_word1[7:0] :
               (gi == 4) ? dval[15:8] : dval[7:0];
            assign fb = is_diag ? db : is_coil ? {7'h00, coil0_state} : hb;
         end
         always @(posedge clk) begin
            if (go)
               rsp_q[gi] <= fb;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Byte sender; the next request waits until the reply is gone
   assign req_ready = (st_q == ST_IDLE);
   assign tx_valid = (st_q == ST_SEND);
   assign tx_data = tx_q;
   assign tx_last = tx_valid && (idx_q == len_q);
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= ST_IDLE;
         idx_q <= 5'h00;
         len_q <= 5'h00;
         tx_q <= 8'h00;
      end else begin
         case (st_q)
            ST_IDLE: begin
               // Foreign and broadcast addresses get no reply
               if (go) begin
                  st_q <= ST_SEND;
                  tx_q <= req_addr;
                  idx_q <= 5'h01;
                  len_q <= len_d;
               end
            end
            ST_SEND: begin
               if (tx_ready) begin
                  if (idx_q == len_q) begin
                     st_q <= ST_IDLE;
                  end else begin
                     tx_q <= rsp_q[idx_q];
                     idx_q <= idx_q + 5'h01;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counters: exception, message, checksum, character
   wire wr_do = aw_q & w_q & ~bvalid_q;
   wire ctrl_wr = wr_do && (awaddr_q == `MBDC_A_CTRL) && wstrb_q[0];
   wire sf_clr = go && is_diag && (req_word1 == `MBDC_SF_CLEAR);
   wire sf_rst = go && is_diag && (req_word1 == `MBDC_SF_RESTART);
   wire axi_clr = ctrl_wr && wdata_q[`MBDC_CTRL_CLR];
   wire cnt_clr = port_restart | sf_rst | sf_clr | axi_clr;
   wire ext_exc = exc_sent && (exc_code >= `MBDC_EX_FUNC) && (exc_code <= `MBDC_EX_VALUE);
   wire own_exc = go & excp;
   wire [7:0] inc_v = {1'b0, char_err, 1'b0, crc_err,
      {1'b0, go} + {1'b0, msg_done}, {1'b0, own_exc} + {1'b0, ext_exc}};
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_cnt
         wire [15:0] inc = {14'h0000, inc_v[2*gi+1 -: 2]};
         // Events landing on a clear still count
         always @(posedge clk or posedge sys_rst) begin
            if (sys_rst)
               cnt_q[gi] <= 16'h0000;
            else if (cnt_clr)
               cnt_q[gi] <= inc;
            else
               cnt_q[gi] <= cnt_q[gi] + inc;
         end
      end
   endgenerate

   // Diagnostic register; persistent causes reassert at once
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         diag_q <= 16'h0000;
      else if (sf_clr | axi_clr)
         diag_q <= diag_set;
      else
         diag_q <= diag_q | diag_set;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line configuration: factory, saved image, fallback, bus writes
   wire cfg_wr = wr_do && (awaddr_q == `MBDC_A_CFG);
   wire [31:0] cfg_m = lane_merge({18'h00000, cfg_q}, wdata_q, wstrb_q);
   wire [13:0] cfg_n = cfg_m[13:0];
   wire nv_bad = nv_load && !(nv_ok && cfg_ok(nv_cfg));
   wire fall = hw_fail | nv_bad;
   wire cfg_rej = cfg_wr && !cfg_ok(cfg_n);
   reg [13:0] cfg_d;
   always @* begin
      cfg_d = cfg_q;
      if (fall)
         cfg_d = FALL_CFG;
      else if (nv_load)
         cfg_d = nv_cfg;
      else if (cfg_wr) begin
         // Each invalid field keeps its stored value
         if (addr_ok(cfg_n[`MBDC_CFG_ADDR]))
            cfg_d[`MBDC_CFG_ADDR] = cfg_n[`MBDC_CFG_ADDR];
         if (cfg_n[`MBDC_CFG_BAUD] <= `MBDC_BAUD_MAX)
            cfg_d[`MBDC_CFG_BAUD] = cfg_n[`MBDC_CFG_BAUD];
         if (cfg_n[`MBDC_CFG_PAR] <= `MBDC_PAR_MAX)
            cfg_d[`MBDC_CFG_PAR] = cfg_n[`MBDC_CFG_PAR];
         cfg_d[`MBDC_CFG_STOP] = cfg_n[`MBDC_CFG_STOP];
      end
   end
   // Changes are volatile until software asks for a save
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_q <= FACT_CFG;
         nv_save_q <= 1'b0;
         nv_wdata_q <= 14'h0000;
      end else begin
         cfg_q <= cfg_d;
         nv_save_q <= ctrl_wr && wdata_q[`MBDC_CTRL_SAVE];
         if (ctrl_wr && wdata_q[`MBDC_CTRL_SAVE])
            nv_wdata_q <= cfg_q;
      end
   end
   assign cfg_addr = cfg_q[`MBDC_CFG_ADDR];
   assign cfg_baud = cfg_q[`MBDC_CFG_BAUD];
   assign cfg_parity = cfg_q[`MBDC_CFG_PAR];
   assign cfg_stop = cfg_q[`MBDC_CFG_STOP];
   assign nv_save = nv_save_q;
   assign nv_wdata = nv_wdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: sticky, write-one-to-clear, set beats clear
   wire [4:0] ev = {cfg_rej, fall, char_err, crc_err, own_exc | ext_exc};
   wire clr_wr = wr_do && (awaddr_q == `MBDC_A_IRQ_CLR) && wstrb_q[0];
   wire [4:0] clr_m = clr_wr ? wdata_q[4:0] : 5'h00;
   wire en_wr = wr_do && (awaddr_q == `MBDC_A_IRQ_EN);
   wire [31:0] en_m = lane_merge({27'h0000000, en_q}, wdata_q, wstrb_q);
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sts_q <= 5'h00;
         en_q <= 5'h00;
      end else begin
         sts_q <= (sts_q & ~clr_m) | ev;
         if (en_wr)
            en_q <= en_m[4:0];
      end
   end
   assign irq = |(sts_q & en_q);

   ////////////////////////////////////////////////////////////////////////////
   // Register bus slave: address and data in either order
   function wr_map;
      input [7:0] a;
      wr_map = (a == `MBDC_A_CFG) || (a == `MBDC_A_CTRL) ||
         (a == `MBDC_A_IRQ_CLR) || (a == `MBDC_A_IRQ_EN);
   endfunction
   assign s_axi_awready = ~aw_q;
   assign s_axi_wready = ~w_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   reg [31:0] rd_d;
   reg rd_hit;
   // Read-back mux; write-only words read as unmapped
   always @* begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `MBDC_A_CFG: rd_d = {18'h00000, cfg_q};
         `MBDC_A_CNT_EM: rd_d = {cnt_q[0], cnt_q[1]};
         `MBDC_A_CNT_ERR: rd_d = {cnt_q[2], cnt_q[3]};
         `MBDC_A_DIAG: rd_d = {16'h0000, diag_q};
         `MBDC_A_IRQ_STS: rd_d = {27'h0000000, sts_q};
         `MBDC_A_IRQ_EN: rd_d = {27'h0000000, en_q};
         default: begin
            rd_d = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bvalid_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bresp_q <= `MBDC_RESP_OK;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `MBDC_RESP_OK;
      end else begin
         if (s_axi_awvalid && !aw_q) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_q) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_do) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_map(awaddr_q) ? `MBDC_RESP_OK : `MBDC_RESP_ERR;
         end
         // Both halves held until the response is taken
         if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
         end
         if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_d;
            rresp_q <= rd_hit ? `MBDC_RESP_OK : `MBDC_RESP_ERR;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end
endmodule // mbdc_top

// file: verilog/mbdc_regs.vh
// Constants for the serial diagnostic counter and fallback configuration block
// Behaviour
// - Subfunction 13 replies with the number of exception responses issued.
// - Illegal function, address or value exceptions each bump the exception counter.
// - All diagnostic counters are unsigned 16-bit and wrap to zero.
// - Subfunction 14 replies with the count of received and processed messages.
// - Subfunction 18 replies with the overrun, framing and parity error count.
// - Port restart or clear-counters diagnostic zeroes exception, message and error counters.
// - Counter reply echoes address, function, subfunction, then value high byte first.
// - Factory slave address equals last two decimal serial number digits.
// - Serial number ending in 00 gives factory address 100.
// - Factory port setting is 19.2 kbps, even parity, one stop bit.
// - Invalid address or parameter in a configuration write leaves old value.
// - Settings survive power loss only once saved to nonvolatile memory.
// - Memory corruption or hardware failure forces 19.2 kbps, even, one stop, address 1.
// - Valid slave addresses run 1 to 247; masters may scan them.
// - Read coil 0 and return-query-data both answer, for address probing.
// - Identity read from register 0 gives model text, then serial number.
// - Subfunction 10 clears all counters and diagnostic register; causes may reassert.
// - Subfunction 12 replies with the 16-bit checksum failure count.
`ifndef MBDC_REGS_VH
`define MBDC_REGS_VH
// Bus register byte offsets
`define MBDC_A_CFG 8'h00
`define MBDC_A_CTRL 8'h04
`define MBDC_A_CNT_EM 8'h08
`define MBDC_A_CNT_ERR 8'h0c
`define MBDC_A_DIAG 8'h10
`define MBDC_A_IRQ_STS 8'h14
`define MBDC_A_IRQ_CLR 8'h18
`define MBDC_A_IRQ_EN 8'h1c
`define MBDC_RESP_OK 2'b00
`define MBDC_RESP_ERR 2'b10
// Configuration word layout
`define MBDC_CFG_W 14
`define MBDC_CFG_ADDR 7:0
`define MBDC_CFG_BAUD 10:8
`define MBDC_CFG_PAR 12:11
`define MBDC_CFG_STOP 13
`define MBDC_CTRL_SAVE 0
`define MBDC_CTRL_CLR 1
`define MBDC_IRQ_N 5
// Line settings
`define MBDC_BAUD_19K2 3'h1
`define MBDC_BAUD_MAX 3'h4
`define MBDC_PAR_EVEN 2'h1
`define MBDC_PAR_MAX 2'h2
`define MBDC_STOP_ONE 1'b0
`define MBDC_ADDR_MIN 8'h01
`define MBDC_ADDR_MAX 8'hf7
`define MBDC_ADDR_FALLBACK 8'h01
`define MBDC_ADDR_SN00 8'h64
// Function, subfunction and exception codes
`define MBDC_FC_COILS 8'h01
`define MBDC_FC_HOLD 8'h03
`define MBDC_FC_DIAG 8'h08
`define MBDC_FC_EXC 8'h80
`define MBDC_SF_QUERY 16'h0000
`define MBDC_SF_RESTART 16'h0001
`define MBDC_SF_DIAGREG 16'h0002
`define MBDC_SF_CLEAR 16'h000a
`define MBDC_SF_BUSERR 16'h000c
`define MBDC_SF_EXCCNT 16'h000d
`define MBDC_SF_MSGCNT 16'h000e
`define MBDC_SF_CHRERR 16'h0012
`define MBDC_EX_FUNC 8'h01
`define MBDC_EX_ADDR 8'h02
`define MBDC_EX_VALUE 8'h03
// Identity bank and reply sizes
`define MBDC_ID_WORDS 16'h000a
`define MBDC_LEN_EXC 5'h03
`define MBDC_LEN_COIL 5'h04
`define MBDC_LEN_DIAG 5'h06
`define MBDC_BUF_N 23
`endif

// file: sim/mbdc_top_sva.sv
// Port-level checks for the serial diagnostic block
`timescale 1ns/1ns
module mbdc_top_sva #(
   parameter [31:0] SERIAL_NUM = 32'd12345
) (
   input wire clk,
   input wire sys_rst,
   input wire req_valid,
   input wire req_ready,
   input wire [7:0] req_addr,
   input wire tx_valid,
   input wire tx_ready,
   input wire [7:0] tx_data,
   input wire tx_last,
   input wire hw_fail,
   input wire nv_save,
   input wire [13:0] nv_wdata,
   input wire [7:0] cfg_addr,
   input wire [2:0] cfg_baud,
   input wire [1:0] cfg_parity,
   input wire cfg_stop
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Factory address; a serial ending in 00 would give the illegal address 0
   wire [31:0] sn_mod = SERIAL_NUM % 32'd100;
   wire [7:0] fac_addr = (sn_mod == 32'h0) ? 8'h64 : sn_mod[7:0];
   a_factory_cfg: assert property ($fell(sys_rst) |-> cfg_addr == fac_addr &&
      cfg_baud == 3'h1 && cfg_parity == 2'h1 && !cfg_stop) else $error("factory config wrong");
   a_reply_head: assert property ($rose(tx_valid) |-> tx_data == cfg_addr)
      else $error("reply does not start with address");
   a_byte_hold: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("byte changed while stalled");
   a_busy_refuse: assert property (tx_valid |-> !req_ready)
      else $error("request accepted while replying");
   a_answer_lat: assert property (req_valid && req_ready && req_addr == cfg_addr |=> tx_valid)
      else $error("no reply one cycle after request");
   a_drop_foreign: assert property (req_valid && req_ready && req_addr != cfg_addr |=>
      !tx_valid [*4]) else $error("reply to foreign address");
   a_end_frame: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid && req_ready)
      else $error("frame did not end after last byte");
   a_fallback: assert property (hw_fail |=> cfg_addr == 8'h01 && cfg_baud == 3'h1 &&
      cfg_parity == 2'h1 && !cfg_stop) else $error("no fallback after failure");
   a_cfg_legal: assert property (cfg_addr >= 8'h01 && cfg_addr <= 8'hf7 &&
      cfg_baud <= 3'h4 && cfg_parity != 2'h3) else $error("illegal live config");
   a_save_image: assert property (nv_save |->
      nv_wdata == {cfg_stop, cfg_parity, cfg_baud, cfg_addr} ##1 !nv_save)
      else $error("bad save pulse");
endmodule // mbdc_top_sva
bind mbdc_top mbdc_top_sva #(.SERIAL_NUM(SERIAL_NUM)) sva_u (.*);

// file: sim/mbdc_sink.sv
// Reply sink standing in for the master's receiver
`timescale 1ns/1ns
module mbdc_sink (
   input wire clk,
   input wire sys_rst,
   input wire slow,
   input wire tx_valid,
   input wire [7:0] tx_data,
   input wire tx_last,
   output logic tx_ready
);
   logic [7:0] bf [0:255];
   int n;
   int fr;
   // Slow mode takes every other byte, so the block must hold its byte
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_ready <= 1'b1;
         n <= 0;
         fr <= 0;
      end else begin
         tx_ready <= slow ? !tx_ready : 1'b1;
         if (tx_valid && tx_ready) begin
            bf[n[7:0]] <= tx_data;
            n <= n + 1;
            if (tx_last) fr <= fr + 1;
         end
      end
   end
endmodule // mbdc_sink

// file: sim/tb_top.sv
// Self-checking bench for the diagnostic counter block
`timescale 1ns/1ns
module tb_top;
   localparam [7:0] A = 8'h64;
   localparam [127:0] MID = "MODEL-0000-AAAA ";
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   logic [7:0] req_addr = 8'h00, req_func = 8'h00, exc_code = 8'h00;
   logic [15:0] req_word1 = 16'h0, req_word2 = 16'h0, diag_set = 16'h0;
   logic coil0_state = 1'b0, nv_load = 1'b0, nv_ok = 1'b0, sk_slow = 1'b0;
   logic [13:0] nv_cfg = 14'h0;
   logic [5:0] ev = 6'h0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire req_ready, tx_valid, tx_ready, tx_last, nv_save, cfg_stop, irq;
   wire [7:0] tx_data, cfg_addr;
   wire [13:0] nv_wdata;
   wire [2:0] cfg_baud;
   wire [1:0] cfg_parity, s_axi_bresp, s_axi_rresp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [31:0] s_axi_rdata;
   logic [7:0] ex [0:22];
   logic [13:0] sv = 14'h0;
   logic [31:0] d;
   logic [1:0] r;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   mbdc_top #(.SERIAL_NUM(32'd398700), .MODEL_ID(MID)) dut_u (.*, .msg_done(ev[0]),
      .exc_sent(ev[1]), .crc_err(ev[2]), .char_err(ev[3]), .port_restart(ev[4]),
      .hw_fail(ev[5]));
   mbdc_sink sk (.clk(clk), .sys_rst(sys_rst), .slow(sk_slow), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
   always #10 clk = ~clk;
   // Save image capture and hang guard
   always @(posedge clk) begin
      if (nv_save === 1'b1) sv <= nv_wdata;
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         conclude();
      end
   end
   task conclude();
      if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Event pulses, one cycle each with a gap
   task pl(input [5:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 6'h0;
      @(posedge clk);
   endtask
   // Bus write; ready and valid are settled at the falling edge
   task axw(input [7:0] a, input [31:0] v, output [1:0] rs);
      logic ha, hw, hb;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge clk);
         ha = s_axi_awvalid & s_axi_awready;
         hw = s_axi_wvalid & s_axi_wready;
         hb = s_axi_bready & s_axi_bvalid;
         if (hb) rs = s_axi_bresp;
         @(posedge clk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hb) s_axi_bready <= 1'b0;
      end while (s_axi_bready);
   endtask
   task axr(input [7:0] a, output [31:0] v, output [1:0] rs);
      logic ha, hr;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge clk);
         ha = s_axi_arvalid & s_axi_arready;
         hr = s_axi_rready & s_axi_rvalid;
         if (hr) {v, rs} = {s_axi_rdata, s_axi_rresp};
         @(posedge clk);
         if (ha) s_axi_arvalid <= 1'b0;
         if (hr) s_axi_rready <= 1'b0;
      end while (s_axi_rready);
   endtask
   // One request; the reply is compared byte by byte with ex
   task rq(input [7:0] a, input [7:0] f, input [15:0] w1, input [15:0] w2, input int n);
      int b, i, k;
      logic h;
      b = sk.n;
      i = sk.fr;
      k = 0;
      @(posedge clk);
      {req_addr, req_func, req_word1, req_word2} <= {a, f, w1, w2};
      req_valid <= 1'b1;
      do begin
         @(negedge clk);
         h = req_ready;
         @(posedge clk);
      end while (!h);
      req_valid <= 1'b0;
      while (sk.fr == i && k < 300) begin
         @(negedge clk);
         k++;
      end
      chk(sk.n - b, n);
      for (int j = 0; j < n; j++) chk(sk.bf[b + j], ex[j]);
   endtask
   task d6(input [7:0] a, input [15:0] sf, input [15:0] dt, input [15:0] v);
      {ex[0], ex[1], ex[2], ex[3], ex[4], ex[5]} = {a, 8'h08, sf, v};
      rq(a, 8'h08, sf, dt, 6);
   endtask
   task t_reset();
      chk(cfg_addr, A);
      chk({cfg_stop, cfg_parity, cfg_baud}, 6'h09);
   endtask
   task t_counts();
      exc_code <= 8'h02;
      pl(6'h02);
      exc_code <= 8'h03;
      pl(6'h02);
      exc_code <= 8'h04;
      pl(6'h02);
      repeat (3) pl(6'h01);
      pl(6'h08);
      pl(6'h08);
      pl(6'h04);
      d6(A, 16'h000d, 16'h0, 16'h0002);
      d6(A, 16'h000e, 16'h0, 16'h0004);
      d6(A, 16'h0012, 16'h0, 16'h0002);
      d6(A, 16'h000c, 16'h0, 16'h0001);
      {ex[0], ex[1], ex[2]} = {A, 8'h88, 8'h01};
      rq(A, 8'h08, 16'h0063, 16'h0, 3);
      d6(A, 16'h000d, 16'h0, 16'h0003);
   endtask
   task t_clear();
      axw(8'h04, 32'h2, r);
      d6(A, 16'h000e, 16'h0, 16'h0);
      d6(A, 16'h000d, 16'h0, 16'h0);
      pl(6'h08);
      pl(6'h10);
      d6(A, 16'h0012, 16'h0, 16'h0);
      pl(6'h08);
      d6(A, 16'h000a, 16'h0, 16'h0);
      d6(A, 16'h0012, 16'h0, 16'h0);
      // Character errors held for 65538 cycles: the count wraps to 2
      @(posedge clk);
      ev <= 6'h08;
      repeat (65538) @(posedge clk);
      ev <= 6'h00;
      d6(A, 16'h0012, 16'h0, 16'h0002);
   endtask
   task t_probe();
      logic h;
      coil0_state <= 1'b1;
      {ex[0], ex[1], ex[2], ex[3]} = {A, 8'h01, 8'h01, 8'h01};
      rq(A, 8'h01, 16'h0, 16'h1, 4);
      d6(A, 16'h0000, 16'h00fd, 16'h00fd);
      sk_slow <= 1'b1;
      {ex[0], ex[1], ex[2]} = {A, 8'h03, 8'h10};
      for (int i = 0; i < 16; i++) ex[3 + i] = MID[127 - 8 * i -: 8];
      rq(A, 8'h03, 16'h0, 16'h8, 19);
      sk_slow <= 1'b0;
      h = 1'b0;
      @(posedge clk);
      {req_addr, req_valid} <= {8'h05, 1'b1};
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (8) begin
         @(negedge clk);
         h = h | tx_valid;
      end
      chk(h, 1'b0);
   endtask
   task t_cfg();
      axw(8'h00, 32'h1200, r);
      chk({cfg_stop, cfg_parity, cfg_baud, cfg_addr}, 14'h1264);
      axr(8'h00, d, r);
      chk(d, 32'h1264);
      axr(8'h14, d, r);
      chk(d, 32'h17);
      axw(8'h1c, 32'h10, r);
      @(negedge clk);
      chk(irq, 1'b1);
      axw(8'h18, 32'h10, r);
      @(negedge clk);
      chk(irq, 1'b0);
      axr(8'h20, d, r);
      chk(r, 2'b10);
      axw(8'h04, 32'h1, r);
      repeat (3) @(negedge clk);
      chk(sv, 14'h1264);
   endtask
   task t_fail();
      pl(6'h20);
      chk({cfg_stop, cfg_parity, cfg_baud, cfg_addr}, 14'h0901);
      d6(8'h01, 16'h0000, 16'h00fd, 16'h00fd);
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_counts();
      t_clear();
      t_probe();
      t_cfg();
      t_fail();
      conclude();
   end
endmodule // tb_top
